// ===== hw/sspp_fifo.sv
`timescale 1ns/10ps
module sspp_fifo #(
  parameter int unsigned WIDTH = 46,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr_r;
  logic [PW:0]      rd_ptr_r;
  wire              full_w  = (wr_ptr_r[PW] != rd_ptr_r[PW]) &&
                              (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  wire              empty_w = (wr_ptr_r == rd_ptr_r);
  wire              push_w  = in_valid_i && !full_w;
  wire              pop_w   = out_ready_i && !empty_w;

  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = store[rd_ptr_r[PW-1:0]];

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push_w) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop_w)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Storage carries no reset; only the pointers define what is valid
  always_ff @(posedge ref_clk_i) begin
    if (push_w) store[wr_ptr_r[PW-1:0]] <= in_data_i;
  end

endmodule : sspp_fifo

// ===== hw/sspp_top.sv
// Function
// RULE_01: Write select low at K rise loads address, first word; second word at K-bar rise.
// RULE_02: Read select low at K rise loads address; first word driven at cycle t+2.
// RULE_03: First burst word uses latched address A, second word uses A plus one.
// RULE_04: Both selects high at K rise: no transaction, write data ignored, output off.
// RULE_05: With input clocks stopped, all outputs hold their previous state.
// RULE_06: After power-up both ports are deselected and data outputs are off.
// RULE_07: Write data taken and read data given on rising edges of both clocks.
// RULE_08: Narrow mode: lane select 0 guards bits 8:0, select 1 bits 17:9.
// RULE_09: Narrow mode: both lane selects high writes nothing for that data portion.
// RULE_10: Wide mode: selects 0..3 guard bits 8:0, 17:9, 26:18, 35:27.
// RULE_11: Wide mode: all four lane selects high leaves memory unchanged for that portion.
// RULE_12: Each data portion applies its own sampled lane selects independently.
// RULE_13: Read valid flag rises half a cycle before read data, timed like data.
// RULE_14: PLL-off pin low gives one-cycle read latency instead of two.
`timescale 1ns/10ps
module sspp_top
  import sspp_pkg::*;
(
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rstn_i,
  // Input clock pair from the controller
  input  wire logic                       k_i,
  input  wire logic                       k_n_i,
  // Port selects and address
  input  wire logic                       read_select_n_i,
  input  wire logic                       write_select_n_i,
  input  wire logic [sspp_pkg::ADDR_W-1:0] addr_i,
  // Write data and lane masks
  input  wire logic [sspp_pkg::DATA_W-1:0] d_i,
  input  wire logic [sspp_pkg::LANES-1:0]  byte_lane_select_n_i,
  // Straps
  input  wire logic                       pll_off_pin_n_i,
  input  wire logic                       cfg_wide_i,
  // Read data
  output logic [sspp_pkg::DATA_W-1:0]      q_o,
  output logic                            q_oe_o,
  output logic                            read_valid_flag_o
);

  import sspp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three flops, K and K-bar changes accepted when stages 2 and 3 agree
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic              k_lvl_r;
  logic              kn_lvl_r;
  logic [3:0]        fill_r;

  wire [SYNC_W-1:0] in_vec = {pll_off_pin_n_i, cfg_wide_i, k_i, k_n_i, read_select_n_i,
                              write_select_n_i, byte_lane_select_n_i, addr_i, d_i};

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
    end else begin
      s1_r <= in_vec;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  wire k_agree  = (s2_r[POS_K] == s3_r[POS_K]);
  wire kn_agree = (s2_r[POS_KN] == s3_r[POS_KN]);
  // No edge until the levels hold real pin values, so a reset cannot fake one
  wire sync_ok  = fill_r[3];

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      k_lvl_r  <= 1'b0;
      kn_lvl_r <= 1'b0;
      fill_r   <= '0;
    end else begin
      fill_r   <= {fill_r[2:0], 1'b1};
      if (k_agree)  k_lvl_r  <= s3_r[POS_K];
      if (kn_agree) kn_lvl_r <= s3_r[POS_KN];
    end
  end

  // Only rising edges of either clock matter; falling edges are ignored
  wire              k_rise   = sync_ok && k_agree && s3_r[POS_K] && !k_lvl_r;     // see RULE_07
  wire              kn_rise  = sync_ok && kn_agree && s3_r[POS_KN] && !kn_lvl_r;  // see RULE_07
  wire              half_edge = k_rise || kn_rise;
  wire [DATA_W-1:0] d_s      = s3_r[POS_D +: DATA_W];
  wire sspp_addr_t  a_s      = s3_r[POS_A +: ADDR_W];
  wire [LANES-1:0]  bls_s    = s3_r[POS_BLS +: LANES];
  wire              wide_s   = s3_r[POS_WIDE];
  wire              pll_on_s = s3_r[POS_PLLN];

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode at K rise
  wire rd_start = k_rise && !s3_r[POS_RS];                    // see RULE_02
  wire wr_start = k_rise && !s3_r[POS_WS];                    // see RULE_01
  wire deselect = k_rise && s3_r[POS_RS] && s3_r[POS_WS];     // see RULE_04

  // Narrow mode never writes the two upper lanes
  wire [LANES-1:0] mask_s = wide_s ? bls_s : {MASK_HI18, bls_s[1:0]};  // see RULE_08 RULE_10

  ////////////////////////////////////////////////////////////////////////////
  // Write capture: each portion keeps its own lane mask
  logic             wr_pend_r;
  sspp_addr_t       wr_addr_r;
  logic             stage_v_r;
  logic [WQ_W-1:0]  stage_r;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [WQ_W-1:0]  fifo_out_data;

  wire             wr_word1 = kn_rise && wr_pend_r;                           // see RULE_01
  wire sspp_addr_t wr_addr1 = sspp_addr_t'(wr_addr_r + 1'b1);                 // see RULE_03
  wire [WQ_W-1:0]  cap_w0   = {a_s, d_s, mask_s};                             // see RULE_12
  wire [WQ_W-1:0]  cap_w1   = {wr_addr1, d_s, mask_s};                        // see RULE_12
  wire             cap_any  = wr_start || wr_word1;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (k_rise) begin
      wr_pend_r <= wr_start;
      if (wr_start) wr_addr_r <= a_s;
    end else if (kn_rise) begin
      wr_pend_r <= 1'b0;
    end
  end

  // A staged word waits here while the FIFO is full
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_v_r <= 1'b0;
      stage_r   <= '0;
    end else if (cap_any) begin
      stage_v_r <= 1'b1;
      stage_r   <= wr_start ? cap_w0 : cap_w1;
    end else if (fifo_in_ready) begin
      stage_v_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pipeline, shifted on every half edge
  logic [PIPE_LEN-1:0] pipe_r;
  sspp_addr_t          apipe_r [PIPE_LEN];

  wire [2:0] w0_idx = pll_on_s ? 3'(LAT2_W0) : 3'(LAT1_W0);  // see RULE_14
  wire [2:0] w1_idx = pll_on_s ? 3'(LAT2_W1) : 3'(LAT1_W1);  // see RULE_14
  wire [2:0] vl_idx = w0_idx - 3'h1;

  wire             ev_w0   = half_edge && pipe_r[w0_idx];                      // see RULE_02
  wire             ev_w1   = half_edge && pipe_r[w1_idx];                      // see RULE_07
  wire             ev_vld  = half_edge && (pipe_r[vl_idx] || pipe_r[w0_idx]);  // see RULE_13
  wire             ev_word = ev_w0 || ev_w1;
  wire sspp_addr_t rd_addr = ev_w1 ? sspp_addr_t'(apipe_r[w1_idx] + 1'b1)     // see RULE_03
                                   : apipe_r[w0_idx];

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pipe_r <= PIPE_RST;
    end else if (half_edge) begin
      pipe_r <= {pipe_r[PIPE_LEN-2:0], rd_start};  // see RULE_04
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      apipe_r[0] <= '0;
    end else if (half_edge) begin
      apipe_r[0] <= a_s;
    end
  end

  for (genvar i = 1; i < PIPE_LEN; i++) begin : g_apipe
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        apipe_r[i] <= '0;
      end else if (half_edge) begin
        apipe_r[i] <= apipe_r[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write FIFO; the single memory port favours reads, so draining stalls
  sspp_fifo #(
    .WIDTH (WQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wq (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (stage_v_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (stage_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!ev_word),
    .out_data_o  (fifo_out_data)
  );

  wire             drain   = fifo_out_valid && !ev_word;
  wire sspp_addr_t wq_addr = fifo_out_data[WQ_W-1 -: ADDR_W];
  wire [LANES-1:0] wq_mask = fifo_out_data[LANES-1:0];
  wire [DATA_W-1:0] wq_data = fifo_out_data[LANES +: DATA_W];
  wire [LANES-1:0] lane_we = drain ? ~wq_mask : '0;  // see RULE_09 RULE_11

  ////////////////////////////////////////////////////////////////////////////
  // Memory: one array per lane, unselected lanes keep their contents
  logic [DATA_W-1:0] mem_rd;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [MEM_DEPTH];
    always_ff @(posedge ref_clk_i) begin
      if (lane_we[l]) lane_mem[wq_addr] <= wq_data[l*LANE_W +: LANE_W];  // see RULE_08 RULE_10
    end
    assign mem_rd[l*LANE_W +: LANE_W] = lane_mem[rd_addr];
  end

  wire [DATA_W-1:0] q_nxt = wide_s ? mem_rd
                                   : {{(DATA_W-NARROW_W){1'b0}}, mem_rd[NARROW_W-1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Output flops move only on a half edge, so a stopped clock freezes them
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o               <= Q_RST;   // see RULE_06
      q_oe_o            <= 1'b0;    // see RULE_06
      read_valid_flag_o <= 1'b0;
    end else if (half_edge) begin   // see RULE_05
      if (ev_word) q_o <= q_nxt;
      q_oe_o            <= ev_word;
      read_valid_flag_o <= ev_vld;  // see RULE_13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address of the last first word, held for the burst check
  sspp_addr_t w0_addr_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      w0_addr_r <= '0;
    end else if (ev_w0) begin
      w0_addr_r <= rd_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  deselect_idle_a : assert property (  // see RULE_04
    @(posedge ref_clk_i) disable iff (!rstn_i)
    deselect |=> (pipe_r[0] == 1'b0) && !stage_v_r)
    else $error("deselected cycle started a transaction");

  read_first_a : assert property (  // see RULE_02
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ev_w0 |=> q_oe_o && (q_o == $past(q_nxt)))
    else $error("first read word not driven at its latency");

  oe_cause_a : assert property (  // see RULE_06
    @(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(q_oe_o) |-> $past(ev_word))
    else $error("data output enabled without a read word");

  valid_lead_a : assert property (  // see RULE_13
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (half_edge && pipe_r[vl_idx]) |=> read_valid_flag_o && (q_oe_o == $past(ev_w1)))
    else $error("valid flag did not lead read data");

  burst_next_a : assert property (  // see RULE_03
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ev_w1 |-> (rd_addr == sspp_addr_t'(w0_addr_r + 1'b1)))
    else $error("second burst word not at address plus one");

  write_take_a : assert property (  // see RULE_01
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_start |=> stage_v_r && (stage_r == $past(cap_w0)) ##0 wr_pend_r)
    else $error("first write word not captured");

  neg_take_a : assert property (  // see RULE_07
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_word1 |=> stage_v_r && (stage_r[WQ_W-1 -: ADDR_W] == $past(wr_addr1)) && !wr_pend_r)
    else $error("second write word not captured on opposite edge");

  narrow_mask_a : assert property (  // see RULE_08
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (cap_any && !wide_s) |=> (stage_r[LANES-1:NARROW_W/LANE_W] == MASK_HI18))
    else $error("narrow mode enabled an upper lane");

  empty_mask_a : assert property (  // see RULE_11
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (wq_mask == MASK_NONE) |-> (lane_we == '0))
    else $error("masked portion wrote memory");

  clock_hold_a : assert property (  // see RULE_05
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !half_edge |=> $stable(q_o) && $stable(q_oe_o) && $stable(read_valid_flag_o))
    else $error("outputs changed with no input clock edge");

  narrow_read_a : assert property (  // see RULE_08
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (ev_word && !wide_s) |=> (q_o[DATA_W-1:NARROW_W] == '0))
    else $error("narrow mode drove upper read bits");

endmodule : sspp_top

// ===== inc/sspp_pkg.sv
package sspp_pkg;

  // Data path geometry
  localparam int unsigned DATA_W     = 36;
  localparam int unsigned NARROW_W   = 18;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANES      = 4;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned MEM_DEPTH  = 64;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned WQ_W       = ADDR_W + DATA_W + LANES;

  // Read pipeline: one bit per half clock edge since the read was taken
  localparam int unsigned PIPE_LEN   = 5;
  localparam int unsigned LAT2_W0    = 3;
  localparam int unsigned LAT2_W1    = 4;
  localparam int unsigned LAT1_W0    = 1;
  localparam int unsigned LAT1_W1    = 2;

  // Pin bundle positions inside the input synchroniser vector
  localparam int unsigned POS_D      = 0;
  localparam int unsigned POS_A      = 36;
  localparam int unsigned POS_BLS    = 42;
  localparam int unsigned POS_WS     = 46;
  localparam int unsigned POS_RS     = 47;
  localparam int unsigned POS_KN     = 48;
  localparam int unsigned POS_K      = 49;
  localparam int unsigned POS_WIDE   = 50;
  localparam int unsigned POS_PLLN   = 51;
  localparam int unsigned SYNC_W     = 52;

  // Reset values and lane mask constants
  localparam logic [SYNC_W-1:0]   SYNC_RST  = 52'h0;
  localparam logic [DATA_W-1:0]   Q_RST     = 36'h0;
  localparam logic [PIPE_LEN-1:0] PIPE_RST  = 5'h0;
  localparam logic [LANES-1:0]    MASK_NONE = 4'hF;
  localparam logic [1:0]          MASK_HI18 = 2'h3;

  typedef logic [ADDR_W-1:0] sspp_addr_t;

endpackage : sspp_pkg

// ===== tb/sspp_ctrl_model.sv
`timescale 1ns/10ps
module sspp_ctrl_model
  import sspp_pkg::*;
(
  // Clock and pin drive toward the block
  input  wire logic                   ref_clk_i,
  output logic                        k_o,
  output logic                        k_n_o,
  output logic                        rd_sel_n_o,
  output logic                        wr_sel_n_o,
  // Address, data and lane masks
  output logic [sspp_pkg::ADDR_W-1:0] addr_o,
  output logic [sspp_pkg::DATA_W-1:0] d_o,
  output logic [sspp_pkg::LANES-1:0]  bls_n_o
);
  initial begin
    k_o        = 1'b0;
    k_n_o      = 1'b1;
    rd_sel_n_o = 1'b1;
    wr_sel_n_o = 1'b1;
    addr_o     = 6'h00;
    d_o        = 36'h0;
    bls_n_o    = 4'hF;
  end

  ////////////////////////////////////////////////////////////////////////
  // One K period of 8 ref cycles; pins set 1 cycle ahead, held 3 after
  task automatic kcycle(input logic rs, ws, input sspp_addr_t a,
                        input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] b0, b1);
    @(negedge ref_clk_i);
    rd_sel_n_o <= rs;
    wr_sel_n_o <= ws;
    addr_o     <= a;
    d_o        <= d0;
    bls_n_o    <= b0;
    @(negedge ref_clk_i);
    k_o   <= 1'b1;
    k_n_o <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    // Hold time over: selects and address show garbage, not the old value
    rd_sel_n_o <= ~rs;
    wr_sel_n_o <= ~ws;
    addr_o     <= ~a;
    d_o        <= d1;
    bls_n_o    <= b1;
    @(negedge ref_clk_i);
    k_o   <= 1'b0;
    k_n_o <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
  endtask : kcycle

  // Clocks stand still with K low, K-bar high; data released
  task automatic idle(input int n);
    @(negedge ref_clk_i);
    d_o     <= ~d_o;
    bls_n_o <= ~bls_n_o;
    repeat (n - 1) @(negedge ref_clk_i);
  endtask : idle
endmodule : sspp_ctrl_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sspp_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn, pll_n, wide, k, k_n, rs_n, ws_n, q_oe, vld;
  sspp_addr_t        addr;
  logic [DATA_W-1:0] d, q;
  logic [LANES-1:0]  bls_n;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  int                n_fail, cmp_count;

  always #25 ref_clk = ~ref_clk;

  sspp_top u_dut (.ref_clk_i(ref_clk), .rstn_i(rstn), .k_i(k), .k_n_i(k_n),
    .read_select_n_i(rs_n), .write_select_n_i(ws_n), .addr_i(addr), .d_i(d),
    .byte_lane_select_n_i(bls_n), .pll_off_pin_n_i(pll_n), .cfg_wide_i(wide),
    .q_o(q), .q_oe_o(q_oe), .read_valid_flag_o(vld));
  sspp_ctrl_model u_ctrl (.ref_clk_i(ref_clk), .k_o(k), .k_n_o(k_n), .rd_sel_n_o(rs_n),
    .wr_sel_n_o(ws_n), .addr_o(addr), .d_o(d), .bls_n_o(bls_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk_word(input string nm, input logic [DATA_W-1:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                               input logic [LANES-1:0] bn);
    for (int i = 0; i < LANES; i++) begin
      if (!bn[i] && (wide || i < 2)) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    end
    return o;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic w, p);
    @(negedge ref_clk);
    rstn  = 1'b0;
    wide  = w;
    pll_n = p;
    repeat (8) @(negedge ref_clk);
    chk_bit("q_oe in reset", 1'b0, q_oe);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_bit("q_oe after reset", 1'b0, q_oe);
    chk_bit("valid after reset", 1'b0, vld);
    chk_word("q after reset", 36'h0, q);
  endtask : do_reset

  task automatic wr(input sspp_addr_t a, input logic [DATA_W-1:0] d0, d1,
                    input logic [LANES-1:0] b0, b1);
    sspp_addr_t b;
    b = a + 6'h1;
    u_ctrl.kcycle(1'b1, 1'b0, a, d0, d1, b0, b1);
    mem[a] = merge(mem[a], d0, b0);
    mem[b] = merge(mem[b], d1, b1);
  endtask : wr

  // Read burst; p stops the clocks after the second K period
  task automatic rd(input sspp_addr_t a, input int p);
    int                o;
    sspp_addr_t        b;
    logic [DATA_W-1:0] m;
    o = (pll_n === 1'b1) ? 0 : 8;
    b = a + 6'h1;
    m = wide ? 36'hF_FFFF_FFFF : 36'h0_0003_FFFF;
    fork
      begin
        u_ctrl.kcycle(1'b0, 1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
        u_ctrl.kcycle(1'b1, 1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
        if (p > 0) u_ctrl.idle(p);
        u_ctrl.kcycle(1'b1, 1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
        u_ctrl.kcycle(1'b1, 1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
      end
      begin
        repeat (20 - o) @(negedge ref_clk);
        chk_bit("valid lead", 1'b1, vld);
        chk_bit("q_oe before word0", 1'b0, q_oe);
        repeat (p) @(negedge ref_clk);
        chk_bit("q_oe clocks stopped", 1'b0, q_oe);
        chk_bit("valid clocks stopped", 1'b1, vld);
        repeat (4) @(negedge ref_clk);
        chk_bit("q_oe word0", 1'b1, q_oe);
        chk_word("word0", mem[a] & m, q);
        repeat (4) @(negedge ref_clk);
        chk_word("word1", mem[b] & m, q);
        chk_bit("valid off", 1'b0, vld);
        repeat (4) @(negedge ref_clk);
        chk_bit("q_oe after burst", 1'b0, q_oe);
      end
    join
  endtask : rd

  ////////////////////////////////////////////////////////////////////////
  // Write queue seen through the pins; last, a read and a write share one K rise
  task automatic t_fifo();
    for (int i = 0; i < 4; i++) begin
      wr(sspp_addr_t'(6'h10 + 2 * i), {4{9'(i + 3)}}, {4{9'(i + 7)}}, 4'h0, 4'h0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(sspp_addr_t'(6'h10 + 2 * i), 0);
    end
    mem[6'h20] = 36'h9_8765_4321;
    mem[6'h21] = 36'h1_2345_6789;
    fork
      begin
        u_ctrl.kcycle(1'b0, 1'b0, 6'h20, mem[6'h20], mem[6'h21], 4'h0, 4'h0);
        repeat (3) u_ctrl.kcycle(1'b1, 1'b1, 6'h20, 36'h0, 36'h0, 4'hF, 4'hF);
      end
      begin
        repeat (24) @(negedge ref_clk);
        chk_bit("same edge q_oe word0", 1'b1, q_oe);
        chk_word("same edge word0", mem[6'h20], q);
        repeat (4) @(negedge ref_clk);
        chk_word("same edge word1", mem[6'h21], q);
        chk_bit("same edge q_oe word1", 1'b1, q_oe);
      end
    join
  endtask : t_fifo

  task automatic t_wide();
    wr(6'h05, 36'h1_2345_6789, 36'hA_BCDE_F012, 4'h0, 4'h0);
    wr(6'h3F, 36'h5_A5A5_A5A5, 36'h3_C3C3_C3C3, 4'h0, 4'h0);
    rd(6'h05, 0);
    rd(6'h3F, 0);
  endtask : t_wide

  task automatic t_lanes();
    logic [DATA_W-1:0] p;
    for (int i = 0; i < LANES; i++) begin
      p = {4{9'(i * 37 + 1)}};
      wr(6'h05, p, ~p, ~(4'h1 << i), ~(4'h8 >> i));
      rd(6'h05, 0);
    end
    wr(6'h05, 36'h0, 36'h0, 4'hF, 4'hF);
    rd(6'h05, 0);
  endtask : t_lanes

  task automatic t_nop();
    u_ctrl.kcycle(1'b1, 1'b1, 6'h05, 36'h0, 36'h0, 4'h0, 4'h0);
    repeat (3) u_ctrl.kcycle(1'b1, 1'b1, 6'h05, 36'h0, 36'h0, 4'h0, 4'h0);
    chk_bit("q_oe after idle", 1'b0, q_oe);
    rd(6'h05, 0);
  endtask : t_nop

  task automatic t_narrow();
    do_reset(1'b0, 1'b1);
    wr(6'h09, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 4'h0, 4'h0);
    wr(6'h09, 36'h0, 36'h0, 4'hE, 4'hD);
    rd(6'h09, 0);
    wr(6'h09, 36'h0, 36'h0, 4'h3, 4'h3);
    rd(6'h09, 0);
  endtask : t_narrow

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn      = 1'b0;
    wide      = 1'b1;
    pll_n     = 1'b1;
    n_fail    = 0;
    cmp_count = 0;
    do_reset(1'b1, 1'b1);
    t_fifo();
    t_wide();
    t_lanes();
    t_nop();
    rd(6'h3F, 40);
    do_reset(1'b1, 1'b0);
    rd(6'h05, 0);
    t_narrow();
    end_sim();
  end

  // Run needs about 770 cycles; a hang is cut off well beyond that
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end
endmodule : tb_top
